// >>> rtl/internal_oscillator_block.sv
// Functional notes
// (R01) a trimmable 16 MHz high-frequency source is modelled
// (R02) high-frequency output goes through postscaler and multiplexer
// (R03) high source runs for high codes with internal clock picked
// (R04) clock switch waits until the new source reports ready
// (R05) high ready flag shows the high source is running
// (R06) high locked flag once within 2 percent
// (R07) high stable flag once within 0.5 percent
// (R08) a trimmable 500 kHz medium-frequency source is modelled
// (R09) medium source feeds postscaler offering derived rates
// (R10) medium source runs for medium codes with internal clock picked
// (R11) medium ready flag shows the medium source is running
// (R12) trim is a six-bit signed value, 1f highest, 20 lowest
// (R13) trim resets to zero
// (R14) one trim value steers both high and medium sources
// (R15) trim changes slew gradually, with no completion flag
// (R16) trim never touches the low source or its timers
// (R17) a 31 kHz low source reaches the mux without postscaler
// (R18) low source runs when code 000x and internal clock picked
// (R19) low source also clocks timers and runs while any is on
// (R20) low ready flag shows the low source is running
// (R21) frequency code 0111 is reset default, 000x is low
// (R22) select 1x internal, 01 timer oscillator, 00 config choice
// (R23) oscillator flags are read-only, live, and ignore writes
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module internal_oscillator_block (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic srst, // synchronous reset, high
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic [2:0] cfgClockChoice, // configuration clock choice
    input wire logic powerUpTimerOn, // power-up timer enabled
    input wire logic watchdogTimerOn, // watchdog enabled
    input wire logic failsafeMonitorOn, // clock monitor enabled
    output logic sysClkTick, // one pulse per system clock period
    output logic lfTick, // low source pulse for the timers
    output logic intOscSelected, // block drives the system clock
    output logic hfEnable, // high source enabled
    output logic mfEnable, // medium source enabled
    output logic lfEnable // low source enabled
);
    // ****************************************************
    // register storage and decode
    // ****************************************************
    logic [3:0] intFreqSelect;
    logic [1:0] sysClockSelect;
    logic [5:0] oscTrimValue;
    logic [5:0] trimLive;
    logic hfReadyFlag;
    logic hfLockedFlag;
    logic hfStableFlag;
    logic mfReadyFlag;
    logic lfReadyFlag;
    logic hfTick;
    logic mfTick;
    logic lfRawTick;

    // apb decode
    wire access = psel && penable;
    wire hitCtrl = (paddr == osc_block_pkg::CTRL_OFS);
    wire hitState = (paddr == osc_block_pkg::STATE_OFS);
    wire hitTrim = (paddr == osc_block_pkg::TRIM_OFS);
    wire hitAny = hitCtrl || hitState || hitTrim;
    wire wrCtrl = access && pwrite && hitCtrl;
    wire wrTrim = access && pwrite && hitTrim;

    // control register: frequency code and clock select
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            intFreqSelect <= osc_block_pkg::FSEL_RST; // (R21)
            sysClockSelect <= osc_block_pkg::SCS_RST;
        end
        else if (wrCtrl)
        begin
            intFreqSelect <= pwdata[osc_block_pkg::FSEL_LSB +: 4];
            sysClockSelect <= pwdata[osc_block_pkg::SCS_LSB +: 2];
        end
    end

    // trim register, six-bit two's complement target
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            oscTrimValue <= osc_block_pkg::TRIM_RST; // (R13)
        else if (wrTrim)
            oscTrimValue <= pwdata[5:0]; // (R12)
    end

    // ****************************************************
    // register read path
    // ****************************************************
    logic [31:0] ctrlWord;
    logic [31:0] stateWord;
    logic [31:0] trimWord;
    logic [31:0] readMux;

    // read words, unused bits zero; flags are live and never stored
    always_comb
    begin
        ctrlWord = 32'h00000000;
        ctrlWord[osc_block_pkg::FSEL_LSB +: 4] = intFreqSelect;
        ctrlWord[osc_block_pkg::SCS_LSB +: 2] = sysClockSelect;
        stateWord = 32'h00000000;
        stateWord[osc_block_pkg::ST_HF_RDY] = hfReadyFlag; // (R23)
        stateWord[osc_block_pkg::ST_HF_LCK] = hfLockedFlag; // (R23)
        stateWord[osc_block_pkg::ST_MF_RDY] = mfReadyFlag; // (R23)
        stateWord[osc_block_pkg::ST_LF_RDY] = lfReadyFlag; // (R23)
        stateWord[osc_block_pkg::ST_HF_STB] = hfStableFlag; // (R23)
        trimWord = {26'h0000000, oscTrimValue};
        if (hitCtrl)
            readMux = ctrlWord;
        else if (hitState)
            readMux = stateWord;
        else if (hitTrim)
            readMux = trimWord;
        else
            readMux = 32'h00000000;
    end

    // zero-wait slave; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = access && !hitAny;

    // read data is captured in the setup cycle, stable in access
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            prdata <= 32'h00000000;
        else if (psel && !penable && !pwrite)
            prdata <= readMux;
    end

    // ****************************************************
    // source enables
    // ****************************************************
    // frequency code to source path
    function automatic osc_block_pkg::path_t pathOf(input logic [3:0] code);
        osc_block_pkg::path_t p;
        p = osc_block_pkg::PATH_LF;
        case (code)
            4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'h3:
                p = osc_block_pkg::PATH_HF;
            4'h2, 4'h4, 4'h5, 4'h6, 4'h7:
                p = osc_block_pkg::PATH_MF;
            default:
                p = osc_block_pkg::PATH_LF;
        endcase
        return p;
    endfunction

    // frequency code to postscaler division, as a power of two
    function automatic logic [3:0] divOf(input logic [3:0] code);
        logic [3:0] d;
        d = 4'h0;
        case (code)
            4'hf: d = 4'h0;
            4'he: d = 4'h1;
            4'hd: d = 4'h2;
            4'hc: d = 4'h3;
            4'hb: d = 4'h4;
            4'ha: d = 4'h5;
            4'h9: d = 4'h6;
            4'h8: d = 4'h7;
            4'h7: d = 4'h0;
            4'h6: d = 4'h1;
            4'h5: d = 4'h2;
            4'h4: d = 4'h3;
            4'h3: d = 4'h9;
            4'h2: d = 4'h4;
            default: d = 4'h0;
        endcase
        return d;
    endfunction

    osc_block_pkg::path_t pathSel;
    wire intPicked = sysClockSelect[1] || // (R22)
        (sysClockSelect == osc_block_pkg::SCS_CONFIG &&
        cfgClockChoice == osc_block_pkg::CFG_INTOSC);
    wire timersOn = powerUpTimerOn || watchdogTimerOn || failsafeMonitorOn;
    assign pathSel = pathOf(intFreqSelect); // (R21)
    assign intOscSelected = intPicked;
    assign hfEnable = intPicked && pathSel == osc_block_pkg::PATH_HF; // (R03)
    assign mfEnable = intPicked && pathSel == osc_block_pkg::PATH_MF; // (R10)
    assign lfEnable = (sysClockSelect[1] && // (R18)
        pathSel == osc_block_pkg::PATH_LF) ||
        (intPicked && pathSel == osc_block_pkg::PATH_LF) || timersOn; // (R19)

    // ****************************************************
    // sources and trim
    // ****************************************************
    // one slewed trim feeds both calibrated sources
    trim_slew #(
        .STEP_CYC(osc_block_pkg::SLEW_CYC)
    ) u_slew (
        .sys_clk(sys_clk),
        .srst(srst),
        .target(oscTrimValue),
        .trim(trimLive) // (R15)
    );

    // high-frequency source, 16 MHz nominal
    osc_source #(
        .INC(osc_block_pkg::HF_INC), // (R01)
        .STEP(osc_block_pkg::HF_TRIM_STEP),
        .READY_CYC(osc_block_pkg::HF_READY_CYC),
        .LOCK_CYC(osc_block_pkg::HF_LOCK_CYC),
        .STABLE_CYC(osc_block_pkg::HF_STABLE_CYC)
    ) u_hf (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(hfEnable),
        .trim(trimLive), // (R14)
        .tick(hfTick),
        .ready(hfReadyFlag), // (R05)
        .locked(hfLockedFlag), // (R06)
        .stable(hfStableFlag) // (R07)
    );

    // medium-frequency source, 500 kHz nominal
    osc_source #(
        .INC(osc_block_pkg::MF_INC), // (R08)
        .STEP(osc_block_pkg::MF_TRIM_STEP),
        .READY_CYC(osc_block_pkg::MF_READY_CYC),
        .LOCK_CYC(osc_block_pkg::MF_READY_CYC),
        .STABLE_CYC(osc_block_pkg::MF_READY_CYC)
    ) u_mf (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(mfEnable),
        .trim(trimLive), // (R14)
        .tick(mfTick),
        .ready(mfReadyFlag), // (R11)
        .locked(),
        .stable()
    );

    // low-frequency source, 31 kHz, untrimmed
    osc_source #(
        .INC(osc_block_pkg::LF_INC), // (R17)
        .STEP(24'h000000),
        .READY_CYC(osc_block_pkg::LF_READY_CYC),
        .LOCK_CYC(osc_block_pkg::LF_READY_CYC),
        .STABLE_CYC(osc_block_pkg::LF_READY_CYC)
    ) u_lf (
        .sys_clk(sys_clk),
        .srst(srst),
        .enable(lfEnable),
        .trim(6'h00), // (R16)
        .tick(lfRawTick),
        .ready(lfReadyFlag), // (R20)
        .locked(),
        .stable()
    );

    // ****************************************************
    // clock switch and postscaler
    // ****************************************************
    typedef enum logic {SW_WAIT = 1'b0, SW_RUN = 1'b1} switch_t;
    switch_t swState;
    switch_t next_swState;
    logic [3:0] activeCode;
    logic [8:0] postCnt;

    // the chosen source and whether it has started
    wire srcReady = (pathSel == osc_block_pkg::PATH_HF) ? hfReadyFlag :
        (pathSel == osc_block_pkg::PATH_MF) ? mfReadyFlag : lfReadyFlag;
    wire srcTick = (pathSel == osc_block_pkg::PATH_HF) ? hfTick :
        (pathSel == osc_block_pkg::PATH_MF) ? mfTick : lfRawTick;
    wire codeMoved = activeCode != intFreqSelect;
    wire [3:0] divNow = pathSel == osc_block_pkg::PATH_LF ? 4'h0 : // (R17)
        divOf(intFreqSelect); // (R02)
    wire [8:0] postMask = 9'((10'h001 << divNow) - 10'h001); // (R09)
    wire postHit = (postCnt & postMask) == postMask;

    // output held until the new source reports ready
    always_comb
    begin
        next_swState = swState;
        case (swState)
            SW_WAIT:
                if (srcReady && intPicked && !codeMoved)
                    next_swState = SW_RUN; // (R04)
            SW_RUN:
                if (codeMoved || !srcReady || !intPicked)
                    next_swState = SW_WAIT;
            default:
                next_swState = SW_WAIT;
        endcase
    end

    // switch state and the code now being served
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            swState <= SW_WAIT;
            activeCode <= osc_block_pkg::FSEL_RST;
        end
        else
        begin
            swState <= next_swState;
            activeCode <= intFreqSelect;
        end
    end

    // postscaler counts source edges; restarts on every switch
    always_ff @(posedge sys_clk)
    begin
        if (srst || swState == SW_WAIT)
            postCnt <= 9'h000;
        else if (srcTick)
            postCnt <= postCnt + 9'h001;
    end

    // registered output pulses
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            sysClkTick <= 1'b0;
            lfTick <= 1'b0;
        end
        else
        begin
            sysClkTick <= swState == SW_RUN && srcTick && postHit; // (R02)
            lfTick <= lfRawTick && lfReadyFlag; // (R19)
        end
    end
endmodule

// >>> rtl/osc_block_pkg.sv
package osc_block_pkg;
    // clock of the digital side
    localparam int CLK_HZ = 100000000;
    localparam int CLK_NS = 10;
    // apb register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] STATE_OFS = 12'h004;
    localparam logic [11:0] TRIM_OFS = 12'h008;
    // control register fields
    localparam int FSEL_LSB = 3;
    localparam int SCS_LSB = 0;
    localparam logic [3:0] FSEL_RST = 4'h7;
    localparam logic [1:0] SCS_RST = 2'h0;
    localparam logic [5:0] TRIM_RST = 6'h00;
    // state register bit positions
    localparam int ST_HF_RDY = 4;
    localparam int ST_HF_LCK = 3;
    localparam int ST_MF_RDY = 2;
    localparam int ST_LF_RDY = 1;
    localparam int ST_HF_STB = 0;
    // clock choices
    localparam logic [2:0] CFG_INTOSC = 3'h4;
    localparam logic [1:0] SCS_TIMER1 = 2'h1;
    localparam logic [1:0] SCS_CONFIG = 2'h0;
    // nominal source rates
    localparam longint HF_HZ = 16000000;
    localparam longint MF_HZ = 500000;
    localparam longint LF_HZ = 31000;
    // phase accumulator increments, 24-bit fraction of sys_clk
    localparam int ACC_W = 24;
    localparam logic [23:0] HF_INC = 24'((HF_HZ << ACC_W) / CLK_HZ);
    localparam logic [23:0] MF_INC = 24'((MF_HZ << ACC_W) / CLK_HZ);
    localparam logic [23:0] LF_INC = 24'((LF_HZ << ACC_W) / CLK_HZ);
    // one trim step is about 0.2 percent of the rate
    localparam logic [23:0] HF_TRIM_STEP = HF_INC >> 9;
    localparam logic [23:0] MF_TRIM_STEP = MF_INC >> 9;
    // settle times in ns and their cycle counts (least times round up)
    localparam int HF_READY_NS = 5000;
    localparam int HF_LOCK_NS = 20000;
    localparam int HF_STABLE_NS = 40000;
    localparam int MF_READY_NS = 2000;
    localparam int LF_READY_NS = 10000;
    localparam int SLEW_STEP_NS = 1000;
    localparam logic [12:0] HF_READY_CYC =
        13'((HF_READY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] HF_LOCK_CYC =
        13'((HF_LOCK_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] HF_STABLE_CYC =
        13'((HF_STABLE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] MF_READY_CYC =
        13'((MF_READY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] LF_READY_CYC =
        13'((LF_READY_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [12:0] SLEW_CYC =
        13'((SLEW_STEP_NS + CLK_NS - 1) / CLK_NS);
    // source paths of the output multiplexer
    typedef enum logic [1:0] {PATH_LF = 2'b00, PATH_MF = 2'b01,
        PATH_HF = 2'b11} path_t;
endpackage

// >>> rtl/osc_source.sv
`timescale 1ns/1ps
module osc_source #(
    parameter logic [23:0] INC = 24'h000100,
    parameter logic [23:0] STEP = 24'h000000,
    parameter logic [12:0] READY_CYC = 13'h0001,
    parameter logic [12:0] LOCK_CYC = 13'h0001,
    parameter logic [12:0] STABLE_CYC = 13'h0001
) (
    input wire logic sys_clk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic enable, // source enable
    input wire logic [5:0] trim, // signed trim
    output logic tick, // one pulse per source period
    output logic ready, // source running
    output logic locked, // within lock band
    output logic stable // within stable band
);
    logic [23:0] acc;
    logic [12:0] settle;
    wire signed [24:0] trimAdj = $signed(trim) * $signed({1'b0, STEP});
    wire [23:0] incNow = 24'($signed({1'b0, INC}) + trimAdj);
    wire [24:0] accSum = {1'b0, acc} + {1'b0, incNow};
    // accumulator carry is the source edge; settle counts from enable
    always_ff @(posedge sys_clk)
    begin
        if (srst || !enable)
        begin
            acc <= 24'h000000;
            settle <= 13'h0000;
            tick <= 1'b0;
        end
        else
        begin
            acc <= accSum[23:0];
            tick <= accSum[24];
            if (settle != STABLE_CYC)
                settle <= settle + 13'h0001;
        end
    end
    // status bands grow with settle time
    assign ready = enable && (settle >= READY_CYC);
    assign locked = enable && (settle >= LOCK_CYC);
    assign stable = enable && (settle >= STABLE_CYC);
endmodule

// >>> rtl/trim_slew.sv
`timescale 1ns/1ps
module trim_slew #(
    parameter logic [12:0] STEP_CYC = 13'h0064
) (
    input wire logic sys_clk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic [5:0] target, // written trim value
    output logic [5:0] trim // trim in effect
);
    logic [12:0] slewCnt;
    wire stepNow = (slewCnt == STEP_CYC - 13'h0001);
    wire goUp = $signed(target) > $signed(trim);
    wire goDown = $signed(target) < $signed(trim);
    // moves one trim unit per step period toward the target
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            slewCnt <= 13'h0000;
            trim <= 6'h00;
        end
        else
        begin
            slewCnt <= stepNow ? 13'h0000 : slewCnt + 13'h0001;
            if (stepNow && goUp)
                trim <= trim + 6'h01;
            else if (stepNow && goDown)
                trim <= trim - 6'h01;
        end
    end
endmodule

// >>> tb/internal_oscillator_block_props.sv
`timescale 1ns/1ps
// ********
// port checker
// ********
module internal_oscillator_block_props (
    input wire logic sys_clk, // clock
    input wire logic srst, // reset
    input wire logic psel, // select
    input wire logic penable, // enable
    input wire logic pwrite, // write
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // wdata
    input wire logic [31:0] prdata, // rdata
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic [2:0] cfgClockChoice, // cfg
    input wire logic powerUpTimerOn, // timer
    input wire logic watchdogTimerOn, // timer
    input wire logic failsafeMonitorOn, // monitor
    input wire logic sysClkTick, // tick
    input wire logic lfTick, // low tick
    input wire logic intOscSelected, // selected
    input wire logic hfEnable, // hf on
    input wire logic mfEnable, // mf on
    input wire logic lfEnable // lf on
);
    logic [3:0] code;
    logic [1:0] sys_clock_select;
    logic [5:0] trim;
    // bus decode and expected source choice
    wire logic wrAcc = psel && penable && pwrite;
    wire logic rdSet = psel && !penable && !pwrite;
    wire logic atCtrl = paddr == osc_block_pkg::CTRL_OFS;
    wire logic atTrim = paddr == osc_block_pkg::TRIM_OFS;
    wire logic atStat = paddr == osc_block_pkg::STATE_OFS;
    wire logic mapped = atCtrl || atTrim || atStat;
    wire logic cfgInt = cfgClockChoice == osc_block_pkg::CFG_INTOSC;
    wire logic pick = sys_clock_select[1] || (sys_clock_select == osc_block_pkg::SCS_CONFIG && cfgInt);
    wire logic hfCode = code[3] || code == 4'h3;
    wire logic mfCode = code[3:2] == 2'h1 || code == 4'h2;
    wire logic lfCode = code[3:1] == 3'h0;
    wire logic anyTimer = powerUpTimerOn || watchdogTimerOn
        || failsafeMonitorOn;
    // shadow of the writable fields
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            code <= osc_block_pkg::FSEL_RST;
            sys_clock_select <= osc_block_pkg::SCS_RST;
            trim <= osc_block_pkg::TRIM_RST;
        end
        else if (wrAcc && atCtrl)
        begin
            code <= pwdata[osc_block_pkg::FSEL_LSB +: 4];
            sys_clock_select <= pwdata[osc_block_pkg::SCS_LSB +: 2];
        end
        else if (wrAcc && atTrim)
            trim <= pwdata[5:0];
    end
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // quiet spells of the selection and of the low source
    sequence selOff_s;
        !intOscSelected [*3];
    endsequence
    sequence lfOff_s;
        !lfEnable [*3];
    endsequence
    hf_enable_a: assert property (hfEnable == (hfCode && pick))
        else $error("hf enable wrong");
    mf_enable_a: assert property (mfEnable == (mfCode && pick))
        else $error("mf enable wrong");
    lf_enable_a: assert property (
        lfEnable == ((lfCode && pick) || anyTimer))
        else $error("lf enable wrong");
    int_select_a: assert property (intOscSelected == pick)
        else $error("selection wrong");
    bus_error_a: assert property (psel && penable |-> pslverr == !mapped)
        else $error("error flag wrong");
    ctrl_read_a: assert property (
        rdSet && atCtrl |=> prdata == {25'h0, code, 1'b0, sys_clock_select})
        else $error("control read wrong");
    trim_read_a: assert property (
        rdSet && atTrim |=> prdata == {26'h0, trim})
        else $error("trim read wrong");
    tick_quiet_a: assert property (selOff_s |-> !sysClkTick)
        else $error("tick while unselected");
    lf_quiet_a: assert property (lfOff_s |-> !lfTick)
        else $error("low tick while off");
endmodule

// >>> tb/internal_oscillator_block_tb.sv
`timescale 1ns/1ps
// ********
// bench
// ********
module internal_oscillator_block_tb;
    logic sys_clk, srst, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, sysClkTick, lfTick, intOscSelected;
    logic hfEnable, mfEnable, lfEnable;
    logic [2:0] cfgClockChoice, tmr;
    int mismatches, testsRun, n0, n1;
    // code, select, cfg, timers | hf, mf, lf, selected
    logic [15:0] rows [10] = '{16'hf809, 16'h7205, 16'h0803, 16'h1000,
        16'h1012, 16'h8422, 16'h324b, 16'h2c05, 16'h7180, 16'h0400};
    internal_oscillator_block i_internal_oscillator_block (
        .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfgClockChoice(cfgClockChoice),
        .powerUpTimerOn(tmr[0]), .watchdogTimerOn(tmr[1]),
        .failsafeMonitorOn(tmr[2]), .sysClkTick(sysClkTick), .lfTick(lfTick),
        .intOscSelected(intOscSelected), .hfEnable(hfEnable),
        .mfEnable(mfEnable), .lfEnable(lfEnable));
    // free-running clock
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wrapUp();
        if (mismatches == 0 && testsRun > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge sys_clk);
    endtask
    // one apb transfer, setup then access until ready
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            mismatches++;
            $display("BAD %0t apb timeout", $time);
            wrapUp();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic flags(input int c, input logic [31:0] want);
        idle(c);
        apb(1'b0, osc_block_pkg::STATE_OFS, 32'h0);
        chk(rd, want);
    endtask
    task automatic ticks(input int c, output int k);
        k = 0;
        repeat (c)
        begin
            @(posedge sys_clk);
            k += sysClkTick === 1'b1;
        end
    endtask
    // output tick count over a fixed window for one code
    task automatic rate(input logic [3:0] k, input int want);
        int got;
        apb(1'b1, osc_block_pkg::CTRL_OFS, {25'h0, k, 3'h2});
        idle(600);
        ticks(4000, got);
        chk({31'h0, got >= want - 2 && got <= want + 2}, 32'h1);
    endtask
    // cycles between two low-source pulses
    task automatic lfPeriod(output int p);
        int k;
        k = 0;
        p = 0;
        while (lfTick !== 1'b1 && k < 9000)
        begin
            @(posedge sys_clk);
            k++;
        end
        do
        begin
            @(posedge sys_clk);
            p++;
        end
        while (lfTick !== 1'b1 && p < 9000);
        if (p >= 9000 || k >= 9000)
        begin
            mismatches++;
            $display("BAD %0t low tick timeout", $time);
            wrapUp();
        end
    endtask
    // main sequence
    initial
    begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cfgClockChoice = osc_block_pkg::CFG_INTOSC;
        tmr = 3'h0;
        mismatches = 0;
        testsRun = 0;
        repeat (4) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        chk({31'h0, mfEnable}, 32'h1);
        apb(1'b0, osc_block_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h38);
        apb(1'b0, osc_block_pkg::TRIM_OFS, 32'h0);
        chk(rd, 32'h0);
        flags(0, 32'h0);
        foreach (rows[i])
        begin
            cfgClockChoice <= rows[i][9:7];
            tmr <= rows[i][6:4];
            apb(1'b1, osc_block_pkg::CTRL_OFS,
                {25'h0, rows[i][15:12], 1'b0, rows[i][11:10]});
            chk({hfEnable, mfEnable, lfEnable, intOscSelected},
                rows[i][3:0]);
        end
        cfgClockChoice <= 3'h0;
        tmr <= 3'h0;
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, osc_block_pkg::CTRL_OFS, {25'h0, 4'(c), 3'h2});
            chk({hfEnable, mfEnable, lfEnable}, {c[3] || c == 3,
                c[3:2] == 1 || c == 2, c[3:1] == 0});
        end
        apb(1'b1, osc_block_pkg::CTRL_OFS, 32'h2);
        idle(20);
        apb(1'b1, osc_block_pkg::CTRL_OFS, 32'h7a);
        flags(400, 32'h0);
        flags(200, 32'h10);
        flags(1500, 32'h18);
        flags(2000, 32'h19);
        apb(1'b1, osc_block_pkg::CTRL_OFS, 32'h2);
        flags(0, 32'h0);
        flags(1100, 32'h2);
        apb(1'b1, osc_block_pkg::CTRL_OFS, 32'h3a);
        flags(300, 32'h4);
        apb(1'b1, osc_block_pkg::STATE_OFS, 32'hff);
        flags(0, 32'h4);
        apb(1'b1, 12'h00c, 32'hff);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h0);
        rate(4'h7, 20);
        rate(4'h8, 5);
        rate(4'he, 320);
        rate(4'hf, 640);
        tmr <= 3'h1;
        lfPeriod(n0);
        apb(1'b1, osc_block_pkg::TRIM_OFS, 32'h1f);
        idle(3500);
        ticks(4000, n1);
        chk({31'h0, n1 > 660}, 32'h1);
        lfPeriod(n1);
        chk({31'h0, n1 >= n0 - 1 && n1 <= n0 + 1}, 32'h1);
        apb(1'b1, osc_block_pkg::TRIM_OFS, 32'hffffffe0);
        apb(1'b0, osc_block_pkg::TRIM_OFS, 32'h0);
        chk(rd, 32'h20);
        idle(6600);
        ticks(4000, n1);
        chk({31'h0, n1 < 620}, 32'h1);
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, osc_block_pkg::CTRL_OFS, 32'h0);
        chk(rd, 32'h38);
        apb(1'b0, osc_block_pkg::TRIM_OFS, 32'h0);
        chk(rd, 32'h0);
        wrapUp();
    end
endmodule
bind internal_oscillator_block internal_oscillator_block_props
    i_internal_oscillator_block_props (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfgClockChoice(cfgClockChoice),
    .powerUpTimerOn(powerUpTimerOn), .watchdogTimerOn(watchdogTimerOn),
    .failsafeMonitorOn(failsafeMonitorOn), .sysClkTick(sysClkTick),
    .lfTick(lfTick), .intOscSelected(intOscSelected),
    .hfEnable(hfEnable), .mfEnable(mfEnable), .lfEnable(lfEnable));
